//--- host_model.sv
// Host processor model behind the tail-tagged port: sends descriptors, takes verdicts.
// Assumes one clock, synchronous active-high reset, and the bench stepping it by its tasks.
`timescale 1ns/1ps
`default_nettype none
module host_model
    import stp_gate_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    output logic desc_valid_o,
    input wire logic desc_ready_i,
    output desc_t desc_o,
    input wire logic verdict_valid_i,
    output logic verdict_ready_o,
    input wire verdict_t verdict_i
);
    // ---------------------------------------------
    // Send and receive
    // ---------------------------------------------
    logic stall = 1'b0;
    verdict_t got_q[$];
    initial begin
        desc_valid_o = 1'b0;
        desc_o = '0;
    end
    // Consumer takes no verdict while stalled
    assign verdict_ready_o = !stall;
    // dest and override bit chosen by caller
    task automatic send(input desc_t d, input int bound, output logic ok);
        int n;
        n = 0;
        desc_valid_o <= 1'b1;
        desc_o <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (!desc_ready_i && n < bound);
        ok = desc_ready_i;
    endtask
    // Released bus shows garbage, never the old word
    task automatic idle();
        desc_valid_o <= 1'b0;
        desc_o <= ~desc_o;
    endtask
    // Collect every verdict taken
    always @(posedge clk_i) begin
        if (!srst_i && verdict_valid_i && verdict_ready_o) begin
            got_q.push_back(verdict_i);
        end
    end
endmodule
`default_nettype wire

//--- stp_gate.sv
// Descriptor FIFO and spanning tree port state gate.
// Assumes one 20 MHz clock, synchronous reset and an APB master.
//
// How it works
// - Tail-tag-enabled port is the host port
// - Three bits per port pick one state
// - Disable: no frames, no learning
// - Blocking: only port-to-host traffic, no learning
// - Listening: host traffic both ways, no learning
// - Learning: host traffic only, learning on
// - Forwarding: normal traffic and learning
// - Override-matched frames still reach host
// - Blocking override without lookup ignores transmit enable
`timescale 1ns/1ps
`include "stp_gate_params.svh"
`default_nettype none

// ---------------------------------------------
// Descriptor FIFO
// ---------------------------------------------
module desc_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;
    // Flags are flops so the ports stay glitch free
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data_o = mem[rd_ptr];
    // Storage, written only on push
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
    // Pointers and honest full and empty
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_o <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count <= next_count;
            in_ready_o <= next_count < (AW+1)'(DEPTH);
            out_valid_o <= next_count != '0;
        end
    end
    fifo_bound_a: assert property (@(posedge clk_i) disable iff (srst_i)
        count <= (AW+1)'(DEPTH))
        else $error("fifo count past depth");
endmodule

// ---------------------------------------------
// Port state gate, top
// ---------------------------------------------
module stp_gate
    import stp_gate_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic desc_valid_i,
    output logic desc_ready_o,
    input wire desc_t desc_i,
    output logic verdict_valid_o,
    input wire logic verdict_ready_i,
    output verdict_t verdict_o
);
    localparam int NP = `NPORTS;

    // Class of a port from its three bits
    function automatic stp_state_t port_state(input port_cfg_t c);
        if (c.tx_en && c.rx_en && !c.learn_dis) begin
            port_state = ST_FWD;
        end else if (!c.tx_en && !c.rx_en && !c.learn_dis) begin
            port_state = ST_LEARN;
        end else if (!c.tx_en && !c.rx_en) begin
            port_state = ST_CLOSED;
        end else begin
            port_state = ST_ODD;
        end
    endfunction

    port_cfg_t cfg [NP];
    logic [NP-1:0] host_sel;
    logic [31:0] drop_cnt;
    logic [31:0] pass_cnt;
    logic fifo_valid;
    logic fifo_pop;
    logic [$bits(desc_t)-1:0] fifo_raw;
    desc_t head;

    // ---------------------------------------------
    // Buffer in the descriptor path
    // ---------------------------------------------
    // Verdict stall reaches the source through desc_ready_o
    desc_fifo #(
        .W($bits(desc_t)),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .in_valid_i(desc_valid_i),
        .in_ready_o(desc_ready_o),
        .in_data_i(desc_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_raw)
    );
    assign head = desc_t'(fifo_raw);

    // ---------------------------------------------
    // Host port and per-port masks
    // ---------------------------------------------
    logic [NP-1:0] host_bit;
    logic [NP-1:0] tx_ok;
    logic [NP-1:0] src_bit;
    logic [NP-1:0] all_ports;
    logic [NP-1:0] fwd_mask;
    logic [NP-1:0] host_mask;
    logic [NP-1:0] next_egress;
    logic host_valid;
    logic src_valid;
    logic from_host;
    port_cfg_t src_cfg;
    logic next_learn;

    assign host_bit = host_sel & (~host_sel + NP'(1));
    assign host_valid = host_sel != '0;
    assign all_ports = {NP{1'b1}};
    assign src_valid = head.src < 3'(NP);
    assign src_bit = src_valid ? NP'(1) << head.src : '0;
    assign from_host = host_valid && (src_bit == host_bit);
    assign src_cfg = src_valid ? cfg[head.src] : port_cfg_t'(`PORT_CFG_RST);

    // transmit bit per port, host always open
    generate
        for (genvar i = 0; i < NP; i++) begin : g_txok
            assign tx_ok[i] = cfg[i].tx_en || host_bit[i];
        end
    endgenerate

    assign host_mask = head.dest & (head.blk_ovr && !head.lookup ? all_ports : tx_ok);
    assign fwd_mask = head.dest & tx_ok;

    // override match still goes to host
    always_comb begin
        next_egress = '0;
        if (!src_valid) begin
            next_egress = '0;
        end else if (from_host) begin
            next_egress = host_mask & ~src_bit;
        end else if (src_cfg.rx_en) begin
            next_egress = fwd_mask & ~src_bit;
        end else if (head.ovr_hit) begin
            next_egress = host_bit;
        end
    end

    assign next_learn = src_valid && !src_cfg.learn_dis;

    // ---------------------------------------------
    // Verdict register
    // ---------------------------------------------
    logic load;
    assign load = fifo_valid && (!verdict_valid_o || verdict_ready_i);
    assign fifo_pop = load;

    // Holds until the consumer takes it
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            verdict_valid_o <= 1'b0;
            verdict_o <= '0;
        end else if (load) begin
            verdict_valid_o <= 1'b1;
            verdict_o.egress <= next_egress;
            verdict_o.learn <= next_learn;
            verdict_o.drop <= next_egress == '0;
        end else if (verdict_ready_i) begin
            verdict_valid_o <= 1'b0;
        end
    end
    // Counters wrap, software takes differences
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            drop_cnt <= '0;
            pass_cnt <= '0;
        end else if (load) begin
            drop_cnt <= drop_cnt + 32'(next_egress == '0);
            pass_cnt <= pass_cnt + 32'(next_egress != '0);
        end
    end

    // ---------------------------------------------
    // APB slave, one wait state
    // ---------------------------------------------
    logic access;
    logic wr_en;
    logic [5:0] word;
    logic is_port;
    logic mapped;
    logic [31:0] rd_mux;
    logic [2*NP-1:0] states;

    assign access = psel_i && penable_i && !pready_o;
    assign wr_en = psel_i && penable_i && pready_o && pwrite_i && mapped;  // Lands with pready
    assign word = paddr_i[7:2];
    assign is_port = paddr_i[1:0] == 2'b00 && paddr_i < `REG_HOST_SEL;
    assign mapped = paddr_i[1:0] == 2'b00 && paddr_i <= `REG_STATES;

    // Status word of all port classes
    generate
        for (genvar i = 0; i < NP; i++) begin : g_state
            assign states[2*i+1:2*i] = port_state(cfg[i]);
        end
    endgenerate

    // Read selection
    always_comb begin
        rd_mux = '0;
        if (is_port) begin
            rd_mux = {29'h0, cfg[word[2:0]]};
        end else if (paddr_i == `REG_HOST_SEL) begin
            rd_mux = {26'h0, host_sel};
        end else if (paddr_i == `REG_DROP_CNT) begin
            rd_mux = drop_cnt;
        end else if (paddr_i == `REG_PASS_CNT) begin
            rd_mux = pass_cnt;
        end else if (paddr_i == `REG_STATES) begin
            rd_mux = {20'h0, states};
        end
    end
    generate
        for (genvar i = 0; i < NP; i++) begin : g_cfg
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    cfg[i] <= port_cfg_t'(`PORT_CFG_RST);
                end else if (wr_en && is_port && word == 6'(i)) begin
                    cfg[i].tx_en <= pwdata_i[`BIT_TX_EN];
                    cfg[i].rx_en <= pwdata_i[`BIT_RX_EN];
                    cfg[i].learn_dis <= pwdata_i[`BIT_LEARN_DIS];
                end
            end
        end
    endgenerate
    // Host selection register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            host_sel <= `HOST_SEL_RST;
        end else if (wr_en && paddr_i == `REG_HOST_SEL) begin
            host_sel <= pwdata_i[NP-1:0];
        end
    end
    // Answer one cycle into the access phase
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end else begin
            pready_o <= access;
            pslverr_o <= access && !mapped;
            prdata_o <= access && !pwrite_i ? rd_mux : '0;
        end
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    sequence s_load;
        load;
    endsequence
    sequence s_apb_req;
        psel_i && penable_i && !pready_o;
    endsequence
    // only one host port at a time
    host_onehot_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $onehot0(host_bit) && ((host_bit & ~host_sel) == '0))
        else $error("host port not unique");
    // closed receiver sends no user frame
    rx_closed_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (s_load and (src_valid && !from_host && !src_cfg.rx_en && !head.ovr_hit))
        |=> verdict_o.drop && verdict_o.egress == '0)
        else $error("closed receiver forwarded");
    ovr_host_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (s_load and (src_valid && !from_host && !src_cfg.rx_en && head.ovr_hit))
        |=> verdict_o.egress == $past(host_bit))
        else $error("override frame lost");
    learn_bit_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (s_load and src_valid)
        |=> verdict_o.learn == !$past(src_cfg.learn_dis))
        else $error("learn flag wrong");
    // non-host frame never hits tx-closed port
    tx_closed_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (s_load and !from_host)
        |=> (verdict_o.egress & ~$past(tx_ok)) == '0)
        else $error("frame to tx-closed port");
    blk_ovr_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (s_load and (src_valid && from_host && head.blk_ovr && !head.lookup))
        |=> verdict_o.egress == ($past(head.dest) & ~$past(src_bit)))
        else $error("override egress masked");
    // open ports pass the lookup mask
    fwd_state_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (s_load and (src_valid && !from_host && port_state(src_cfg) == ST_FWD))
        |=> verdict_o.egress == ($past(fwd_mask) & ~$past(src_bit)))
        else $error("forwarding state blocked");
    // closed port output only toward host
    closed_host_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (s_load and (src_valid && !from_host && port_state(src_cfg) == ST_CLOSED))
        |=> (verdict_o.egress & ~$past(host_bit)) == '0)
        else $error("closed port reached non-host");
    // written bits appear two edges later
    cfg_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (s_apb_req and (pwrite_i && is_port && paddr_i == `REG_PORT_BASE))
        |=> ##1 cfg[0] == port_cfg_t'($past(pwdata_i[2:0], 2)))
        else $error("port bits not stored");
    // Answer arrives exactly one cycle after request
    apb_wait_a: assert property (@(posedge clk_i) disable iff (srst_i)
        s_apb_req |=> pready_o ##1 !pready_o)
        else $error("apb answer timing");
    // Verdict holds while stalled
    verdict_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        verdict_valid_o && !verdict_ready_i |=> verdict_valid_o && $stable(verdict_o))
        else $error("verdict changed while stalled");
endmodule
`default_nettype wire

//--- stp_gate_params.svh
// Constants for the spanning tree port state gate.
// Assumes byte addresses on a 32-bit APB, one word per register.
`ifndef STP_GATE_PARAMS_SVH
`define STP_GATE_PARAMS_SVH

// ---------------------------------------------
// Register map
// ---------------------------------------------
`define NPORTS 6
`define REG_PORT_BASE 8'h00
`define REG_HOST_SEL 8'h18
`define REG_DROP_CNT 8'h1c
`define REG_PASS_CNT 8'h20
`define REG_STATES 8'h24

// ---------------------------------------------
// Fields and reset values
// ---------------------------------------------
`define BIT_TX_EN 0
`define BIT_RX_EN 1
`define BIT_LEARN_DIS 2
`define PORT_CFG_RST 3'b011
`define HOST_SEL_RST 6'h20
`define FIFO_DEPTH 16
`define FIFO_AW 4

`endif

//--- stp_gate_pkg.sv
// Types for the spanning tree port state gate.
// Assumes stp_gate_params.svh is compiled alongside.
`default_nettype none
package stp_gate_pkg;
    // Frame descriptor from the lookup stage
    typedef struct packed {
        logic [2:0] src;
        logic [5:0] dest;
        logic ovr_hit;
        logic lookup;
        logic blk_ovr;
    } desc_t;
    // Per-frame verdict
    typedef struct packed {
        logic [5:0] egress;
        logic learn;
        logic drop;
    } verdict_t;
    // Per-port state bits
    typedef struct packed {
        logic learn_dis;
        logic rx_en;
        logic tx_en;
    } port_cfg_t;
    // Port state class seen by software
    typedef enum logic [1:0] {
        ST_CLOSED = 2'b00,
        ST_LEARN = 2'b01,
        ST_FWD = 2'b10,
        ST_ODD = 2'b11
    } stp_state_t;
endpackage
`default_nettype wire

//--- tb.sv
// Self-checking bench for the port state gate.
// Assumes the design package and register constants are compiled first.
`timescale 1ns/1ps
`include "stp_gate_params.svh"
`default_nettype none
module tb;
    import stp_gate_pkg::*;
    // ---------------------------------------------
    // Clock, wires, instances
    // ---------------------------------------------
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, dv, dr, vv, vr;
    desc_t dd;
    verdict_t vd;
    verdict_t exp_q[$];
    int mismatches = 0;
    int num_checks = 0;
    always #25 clk_i = ~clk_i;
    stp_gate i_stp_gate (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .desc_valid_i(dv), .desc_ready_o(dr), .desc_i(dd),
        .verdict_valid_o(vv), .verdict_ready_i(vr), .verdict_o(vd));
    host_model i_host_model (.clk_i(clk_i), .srst_i(srst_i), .desc_valid_o(dv),
        .desc_ready_i(dr), .desc_o(dd), .verdict_valid_i(vv), .verdict_ready_o(vr),
        .verdict_i(vd));
    // ---------------------------------------------
    // Shared tasks
    // ---------------------------------------------
    task automatic fail(input string m);
        mismatches++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        num_checks++;
        if (g !== e) fail(m);
    endtask
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (!pready_o && n < 20);
        if (!pready_o) begin
            fail("apb timeout");
            results();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Send one descriptor and remember its expected verdict
    task automatic sv(input desc_t d, input verdict_t e);
        logic ok;
        i_host_model.send(d, 40, ok);
        if (!ok) begin
            fail("descriptor not taken");
            results();
        end
        exp_q.push_back(e);
    endtask
    // Wait for all verdicts, compare in order
    task automatic drain();
        int n;
        n = 0;
        i_host_model.idle();
        while (i_host_model.got_q.size() < exp_q.size() && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        if (i_host_model.got_q.size() < exp_q.size()) begin
            fail("verdict timeout");
            results();
        end
        chk(i_host_model.got_q.size(), exp_q.size(), "verdict count");
        foreach (exp_q[i]) begin
            if (i < i_host_model.got_q.size()) chk(i_host_model.got_q[i], exp_q[i], "verdict");
        end
        exp_q.delete();
        i_host_model.got_q.delete();
    endtask
    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic t_reset_regs();
        logic [31:0] r;
        logic e;
        apb(1'b0, `REG_PORT_BASE, 32'h0, r, e);
        chk(r, 32'h3, "port bits reset");
        apb(1'b0, `REG_HOST_SEL, 32'h0, r, e);
        chk(r, 32'h20, "host select reset");
        apb(1'b0, 8'h80, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1, "unmapped read");
        $display("test reset_regs done");
    endtask
    // Host on port 0, ports 1..5 disable, blocking, listening, learning, forwarding
    task automatic t_states();
        logic [2:0] cfg[6] = '{3'b011, 3'b100, 3'b100, 3'b100, 3'b000, 3'b011};
        logic [31:0] r;
        logic e;
        apb(1'b1, `REG_HOST_SEL, 32'h1, r, e);
        foreach (cfg[i]) apb(1'b1, `REG_PORT_BASE + 8'(4 * i), {29'h0, cfg[i]}, r, e);
        foreach (cfg[i]) begin
            apb(1'b0, `REG_PORT_BASE + 8'(4 * i), 32'h0, r, e);
            chk(r, {29'h0, cfg[i]}, "port bits");
        end
        apb(1'b0, `REG_STATES, 32'h0, r, e);
        chk(r, 32'h902, "state classes");
        sv(desc_t'{3'd1, 6'h3f, 1'b0, 1'b0, 1'b0}, verdict_t'{6'h00, 1'b0, 1'b1});
        sv(desc_t'{3'd1, 6'h01, 1'b1, 1'b0, 1'b0}, verdict_t'{6'h01, 1'b0, 1'b0});
        sv(desc_t'{3'd2, 6'h01, 1'b1, 1'b0, 1'b0}, verdict_t'{6'h01, 1'b0, 1'b0});
        sv(desc_t'{3'd3, 6'h3f, 1'b0, 1'b0, 1'b0}, verdict_t'{6'h00, 1'b0, 1'b1});
        sv(desc_t'{3'd4, 6'h3f, 1'b0, 1'b0, 1'b0}, verdict_t'{6'h00, 1'b1, 1'b1});
        sv(desc_t'{3'd5, 6'h3f, 1'b0, 1'b0, 1'b0}, verdict_t'{6'h01, 1'b1, 1'b0});
        sv(desc_t'{3'd0, 6'h38, 1'b0, 1'b0, 1'b0}, verdict_t'{6'h20, 1'b1, 1'b0});
        sv(desc_t'{3'd0, 6'h38, 1'b0, 1'b0, 1'b1}, verdict_t'{6'h38, 1'b1, 1'b0});
        sv(desc_t'{3'd0, 6'h38, 1'b0, 1'b1, 1'b1}, verdict_t'{6'h20, 1'b1, 1'b0});
        sv(desc_t'{3'd6, 6'h3f, 1'b1, 1'b0, 1'b0}, verdict_t'{6'h00, 1'b0, 1'b1});
        drain();
        apb(1'b0, `REG_DROP_CNT, 32'h0, r, e);
        chk(r, 32'h4, "drop count");
        apb(1'b0, `REG_PASS_CNT, 32'h0, r, e);
        chk(r, 32'h6, "pass count");
        $display("test states done");
    endtask
    // Fill the FIFO with the consumer stalled, then drain it
    task automatic t_fifo_fill();
        logic ok;
        int taken;
        desc_t d;
        verdict_t e;
        taken = 0;
        d = desc_t'{3'd5, 6'h3f, 1'b0, 1'b0, 1'b0};
        e = verdict_t'{6'h01, 1'b1, 1'b0};
        i_host_model.stall <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            i_host_model.send(d, 4, ok);
            if (!ok) break;
            taken++;
            exp_q.push_back(e);
        end
        chk(taken, `FIFO_DEPTH + 1, "fill depth");
        repeat (5) @(posedge clk_i);
        chk(i_host_model.got_q.size(), 0, "no verdict while stalled");
        i_host_model.stall <= 1'b0;
        // Refused descriptor stays offered until space frees
        if (!ok) sv(d, e);
        drain();
        $display("test fifo_fill done");
    endtask
    // ---------------------------------------------
    // Verdict and main sequence
    // ---------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        t_reset_regs();
        t_states();
        t_fifo_fill();
        results();
    end
endmodule
`default_nettype wire
